// ===== tb/pfd_chk.sv
// assertion checker for the pfd output stage
`timescale 1ns/1ns
`default_nettype none
`include "pfd_defines.svh"
module pfd_chk
  import pfd_pkg::*;
#(
  parameter int PER_W = 16,
  parameter int DB_W = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [`PFD_ADDR_W-1:0] i_addr,
  input wire logic [`PFD_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [`PFD_DATA_W-1:0] o_rdata,
  // event pins
  input wire logic i_rise_evt,
  input wire logic i_fall_evt,
  // driver outputs
  input wire logic o_out_a_phase1_high,
  input wire logic o_out_b_phase1_low,
  input wire logic o_out_c_phase2_high,
  input wire logic o_out_d_phase2_low,
  input wire logic o_out_e_phase3_high,
  input wire logic o_out_f_phase3_low
);
  logic [7:0] ctrl_q; // control shadow, load bit masked off
  logic [7:0] per_q; // low period byte only
  logic [5:0] str_q;
  logic [1:0] mod_q;
  logic [3:0] quiet_q; // cycles since a control or steering write
  logic [8:0] run_q; // cycles output a held
  logic a_q;
  logic seen_q; // first toggle seen, later runs are whole
  logic [5:0] outs;
  logic single;
  logic compl;
  logic chg;
  assign outs = {o_out_f_phase3_low, o_out_e_phase3_high,
    o_out_d_phase2_low, o_out_c_phase2_high, o_out_b_phase1_low,
    o_out_a_phase1_high};
  assign single = ctrl_q[3:0] == 4'h3;
  assign compl = ctrl_q[3:0] == 4'h5 && quiet_q > 4'h5;
  assign chg = o_out_a_phase1_high != a_q;
  // expected pair, lowest set bit wins
  function automatic logic [5:0] pair(input logic [5:0] s);
    casez (s)
      6'b?????1: pair = 6'h09;
      6'b????10: pair = 6'h21;
      6'b???100: pair = 6'h24;
      6'b??1000: pair = 6'h06;
      6'b?10000: pair = 6'h12;
      6'b100000: pair = 6'h18;
      default: pair = 6'h00;
    endcase
  endfunction
  // shadow of writes plus run and quiet counters
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= 8'h00;
      per_q <= 8'h10;
      str_q <= 6'h00;
      mod_q <= 2'h0;
      quiet_q <= 4'h0;
      run_q <= 9'h000;
      a_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      a_q <= o_out_a_phase1_high;
      run_q <= chg ? 9'h001 : run_q + {8'h00, run_q != 9'h1FF};
      quiet_q <= quiet_q + {3'h0, quiet_q != 4'hF};
      if (chg && single) begin
        seen_q <= 1'b1;
      end
      if (i_wr && i_addr == `PFD_OFS_PER_LO) begin
        per_q <= i_wdata;
      end
      if (i_wr && i_addr == `PFD_OFS_CTRL) begin
        ctrl_q <= i_wdata & 8'hBF;
        seen_q <= 1'b0;
        quiet_q <= 4'h0;
      end
      if (i_wr && i_addr == `PFD_OFS_STR0) begin
        str_q <= i_wdata[5:0];
        quiet_q <= 4'h0;
      end
      if (i_wr && i_addr == `PFD_OFS_STR1) begin
        mod_q <= i_wdata[1:0];
        quiet_q <= 4'h0;
      end
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_a_off;
    !o_out_a_phase1_high;
  endsequence
  sequence s_b_off;
    !o_out_b_phase1_low;
  endsequence
  AST_LEG_NO_OVERLAP: assert property (
    !(|(outs[4:0] & outs[5:1] & 5'h15)))
    else $error("both switches of one leg on");
  AST_ONE_PER_SIDE: assert property (
    $onehot0({outs[4], outs[2], outs[0]}) &&
      $onehot0({outs[5], outs[3], outs[1]}))
    else $error("more than one switch on one side");
  AST_SINGLE_A_ONLY: assert property (
    single && quiet_q > 4'h1 |-> outs[5:1] == 5'h00)
    else $error("single mode drives more than a");
  AST_COMPL_AB_ONLY: assert property (
    compl |-> outs[5:2] == 4'h0)
    else $error("complementary mode drives c to f");
  AST_TOGGLE_SPACING: assert property (
    single && seen_q && chg |->
      run_q == per_q + 9'h001 || run_q == per_q + 9'h002)
    else $error("toggle spacing off");
  AST_STEER_PAIR: assert property (
    ctrl_q[3:0] == 4'h9 && mod_q == 2'h0 && quiet_q > 4'h5
      |-> outs == pair(str_q))
    else $error("steered pair wrong");
  AST_RISE_GAP: assert property (
    compl && ctrl_q[`PFD_CTRL_DBRE] && $fell(o_out_b_phase1_low)
      |-> s_a_off)
    else $error("primary on without rising gap");
  AST_FALL_GAP: assert property (
    compl && ctrl_q[`PFD_CTRL_DBFE] && $fell(o_out_a_phase1_high)
      |-> s_b_off)
    else $error("complement on without falling gap");
  AST_NO_GAP_OFF: assert property (
    compl && !ctrl_q[`PFD_CTRL_DBFE] && $fell(o_out_a_phase1_high)
      |-> o_out_b_phase1_low)
    else $error("gap seen with falling band off");
endmodule
bind pfd_top pfd_chk #(.PER_W(PER_W), .DB_W(DB_W)) u_pfd_chk (
  .i_core_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_rise_evt, .i_fall_evt, .o_out_a_phase1_high, .o_out_b_phase1_low,
  .o_out_c_phase2_high, .o_out_d_phase2_low, .o_out_e_phase3_high,
  .o_out_f_phase3_low);
`default_nettype wire

// ===== tb/pfd_gate_model.sv
// gate driver model that flags shoot-through on any half-bridge
`timescale 1ns/1ns
`default_nettype none
module pfd_gate_model (
  // clock
  input wire logic i_clk,
  // driver inputs a..f
  input wire logic [5:0] i_outs,
  // sticky overlap flag
  output logic o_shoot
);
  initial o_shoot = 1'b0;
  always @(posedge i_clk) begin
    if (|(i_outs[4:0] & i_outs[5:1] & 5'h15)) begin
      o_shoot <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// register-driven testbench for the pfd output stage
`timescale 1ns/1ns
`default_nettype none
`include "pfd_defines.svh"
module testbench;
  logic clk, rst_b, wr, rd, rise_evt, fall_evt, shoot;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [5:0] outs; // a in bit 0 .. f in bit 5
  int errors, num_checks, n;
  logic [7:0] sv [10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
    8'h20, 8'h06, 8'h30, 8'h3F};
  logic [5:0] se [10] = '{6'h00, 6'h09, 6'h21, 6'h24, 6'h06, 6'h12,
    6'h18, 6'h21, 6'h12, 6'h09};
  pfd_top u_pfd_top (.i_core_clk(clk), .i_rst_b(rst_b), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_rise_evt(rise_evt), .i_fall_evt(fall_evt),
    .o_out_a_phase1_high(outs[0]), .o_out_b_phase1_low(outs[1]),
    .o_out_c_phase2_high(outs[2]), .o_out_d_phase2_low(outs[3]),
    .o_out_e_phase3_high(outs[4]), .o_out_f_phase3_low(outs[5]));
  pfd_gate_model u_pfd_gate_model (.i_clk(clk), .i_outs(outs),
    .o_shoot(shoot));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    // let one edge pass so a following call never reassigns the strobe
    @(posedge clk);
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  // total length of k whole runs of output a
  task automatic runs(input int k, output int t);
    logic v;
    int j;
    j = 0;
    t = 0;
    @(negedge clk);
    v = outs[0];
    while (outs[0] === v && j < 400) begin @(negedge clk); j++; end
    repeat (k) begin
      v = outs[0];
      j = 0;
      while (outs[0] === v && j < 400) begin @(negedge clk); j++; end
      t += j;
    end
    @(posedge clk);
  endtask
  // cycles from fall of output s until output p comes on
  task automatic gap(input int s, input int p, output int t);
    int j;
    j = 0;
    t = 0;
    @(negedge clk);
    while (outs[s] !== 1'b1 && j < 400) begin @(negedge clk); j++; end
    while (outs[s] === 1'b1 && j < 800) begin @(negedge clk); j++; end
    while (outs[p] !== 1'b1 && t < 400) begin @(negedge clk); t++; end
    @(posedge clk);
  endtask
  task automatic count_high(input int i, output int t);
    t = 0;
    repeat (60) begin
      @(negedge clk);
      if (outs[i] === 1'b1) t++;
    end
    @(posedge clk);
  endtask
  // hang guard, far beyond the several hundred cycles needed
  initial begin
    #1000000;
    errors++;
    complete_run;
  end
  initial begin
    {rst_b, wr, rd, rise_evt, fall_evt, addr, wdata} = '0;
    errors = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // reset values, then an unmapped slot
    for (int a = 0; a < 10; a++) begin
      rd_reg(a[3:0], d);
      check(d, (a == 1) ? 16'h10 : 16'h00);
    end
    wr_reg(4'hA, 8'h5A);
    rd_reg(4'hA, d);
    check(d, 16'h00);
    // single output, edge pins wiggled and ignored
    wr_reg(`PFD_OFS_PER_LO, 8'h04);
    wr_reg(`PFD_OFS_CTRL, 8'h03);
    rise_evt <= 1'b1;
    runs(1, n);
    check(n[15:0], 16'h5);
    fall_evt <= 1'b1;
    runs(1, n);
    check(n[15:0], 16'h5);
    check(outs[5:1], 16'h0);
    rise_evt <= 1'b0;
    fall_evt <= 1'b0;
    // adjust of 8 overflows on every second event
    wr_reg(`PFD_OFS_CTRL, 8'h00);
    wr_reg(`PFD_OFS_FFA, 8'h08);
    wr_reg(`PFD_OFS_CTRL, 8'h03);
    runs(4, n);
    check(n[15:0], 16'd22);
    // complementary with both bands
    wr_reg(`PFD_OFS_CTRL, 8'h00);
    wr_reg(`PFD_OFS_FFA, 8'h00);
    wr_reg(`PFD_OFS_PER_LO, 8'h14);
    wr_reg(`PFD_OFS_DBR, 8'h03);
    wr_reg(`PFD_OFS_DBF, 8'h05);
    wr_reg(`PFD_OFS_CTRL, 8'h35);
    gap(0, 1, n);
    check(n[15:0], 16'h6);
    gap(1, 0, n);
    check(n[15:0], 16'h4);
    wr_reg(`PFD_OFS_DBF, 8'h02);
    gap(0, 1, n);
    check(n[15:0], 16'h6);
    wr_reg(`PFD_OFS_CTRL, 8'h75);
    runs(2, n);
    gap(0, 1, n);
    check(n[15:0], 16'h3);
    rd_reg(`PFD_OFS_CTRL, d);
    check(d, 16'h35);
    wr_reg(`PFD_OFS_CTRL, 8'h05);
    gap(0, 1, n);
    check(n[15:0], 16'h0);
    // band longer than half period keeps one side off
    for (int k = 0; k < 2; k++) begin
      wr_reg(`PFD_OFS_CTRL, 8'h00);
      wr_reg(`PFD_OFS_PER_LO, 8'h04);
      wr_reg(`PFD_OFS_DBR, k[0] ? 8'h00 : 8'h30);
      wr_reg(`PFD_OFS_DBF, k[0] ? 8'h30 : 8'h00);
      wr_reg(`PFD_OFS_CTRL, 8'h35);
      repeat (20) @(posedge clk);
      count_high(k, n);
      check(n[15:0], 16'h0);
    end
    // three-phase steering table
    wr_reg(`PFD_OFS_CTRL, 8'h00);
    wr_reg(`PFD_OFS_CTRL, 8'h09);
    for (int i = 0; i < 10; i++) begin
      wr_reg(`PFD_OFS_STR0, sv[i]);
      repeat (6) @(posedge clk);
      check(outs, se[i]);
    end
    // status shows the held pair a and d, no band busy
    rd_reg(`PFD_OFS_STAT, d);
    check(d, 16'h09);
    // illegal mode code keeps every output off
    wr_reg(`PFD_OFS_CTRL, 8'h0F);
    repeat (3) @(posedge clk);
    check(outs, 16'h00);
    wr_reg(`PFD_OFS_CTRL, 8'h09);
    // one side modulated, the other held on
    wr_reg(`PFD_OFS_STR0, 8'h01);
    for (int k = 1; k < 3; k++) begin
      wr_reg(`PFD_OFS_STR1, k[7:0]);
      fall_evt <= 1'b1;
      repeat (8) @(posedge clk);
      check(outs, (k == 1) ? 16'h08 : 16'h01);
      fall_evt <= 1'b0;
      rise_evt <= 1'b1;
      repeat (8) @(posedge clk);
      check(outs, 16'h09);
      rise_evt <= 1'b0;
      repeat (4) @(posedge clk);
    end
    check(shoot, 16'h0);
    complete_run;
  end
endmodule
`default_nettype wire

// ===== verilog/pfd_deadband.sv
// rising and falling dead-band counter pair with overlap handling
`timescale 1ns/1ns
`default_nettype none
module pfd_deadband
  import pfd_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // start pulses and enables
  input wire logic i_rise_start,
  input wire logic i_fall_start,
  input wire logic i_rise_en,
  input wire logic i_fall_en,
  // programmed times in clock cycles
  input wire logic [CNT_W-1:0] i_rise_time,
  input wire logic [CNT_W-1:0] i_fall_time,
  // count running flags
  output logic o_rise_busy,
  output logic o_fall_busy
);
  logic [CNT_W-1:0] rcnt_q, rcnt_d; // rising count
  logic [CNT_W-1:0] fcnt_q, fcnt_d; // falling count
  logic rbusy_q, rbusy_d;
  logic fbusy_q, fbusy_d;

  // next count values
  always_comb begin
    rcnt_d = rcnt_q;
    fcnt_d = fcnt_q;
    rbusy_d = rbusy_q;
    fbusy_d = fbusy_q;
    if (rbusy_q) begin
      if (rcnt_q == i_rise_time) begin
        rbusy_d = 1'b0;
      end else begin
        rcnt_d = rcnt_q + 1'b1;
      end
    end
    if (fbusy_q) begin
      if (fcnt_q == i_fall_time) begin
        fbusy_d = 1'b0;
      end else begin
        fcnt_d = fcnt_q + 1'b1;
      end
    end
    // rising event starts count
    // restart of a running count simply reloads it from zero
    if (i_rise_start) begin
      rbusy_d = 1'b1;
      rcnt_d = '0;
      fbusy_d = 1'b0;
    end
    if (i_fall_start) begin
      fbusy_d = 1'b1;
      fcnt_d = '0;
      rbusy_d = 1'b0;
    end
    if (!i_rise_en) begin
      rbusy_d = 1'b0;
    end
    if (!i_fall_en) begin
      fbusy_d = 1'b0;
    end
  end

  // count registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rcnt_q <= '0;
      fcnt_q <= '0;
      rbusy_q <= 1'b0;
      fbusy_q <= 1'b0;
    end else begin
      rcnt_q <= rcnt_d;
      fcnt_q <= fcnt_d;
      rbusy_q <= rbusy_d;
      fbusy_q <= fbusy_d;
    end
  end

  assign o_rise_busy = rbusy_q;
  assign o_fall_busy = fbusy_q;
endmodule
`default_nettype wire

// ===== verilog/pfd_defines.svh
// register offsets, field positions, reset values and widths for pfd
`ifndef PFD_DEFINES_SVH
`define PFD_DEFINES_SVH
`define PFD_ADDR_W 4
`define PFD_DATA_W 8
`define PFD_OFS_CTRL 4'h0
`define PFD_OFS_PER_LO 4'h1
`define PFD_OFS_PER_HI 4'h2
`define PFD_OFS_FFA 4'h3
`define PFD_OFS_DBR 4'h4
`define PFD_OFS_DBF 4'h5
`define PFD_OFS_STR0 4'h6
`define PFD_OFS_STR1 4'h7
`define PFD_OFS_STAT 4'h8
`define PFD_CTRL_EN 0
`define PFD_CTRL_MODE_LO 1
`define PFD_CTRL_MODE_HI 3
`define PFD_CTRL_DBRE 4
`define PFD_CTRL_DBFE 5
`define PFD_CTRL_LD 6
`define PFD_STR1_HSMEN 0
`define PFD_STR1_LSMEN 1
`define PFD_RST_CTRL 8'h00
`define PFD_RST_PER 16'h0010
`define PFD_RST_BYTE 8'h00
`define PFD_RST_FFA 4'h0
`define PFD_RST_STR 6'h00
`define PFD_RST_STR1 2'h0
`define PFD_FFA_W 4
`define PFD_STR_W 6
`define PFD_OUT_A 0
`define PFD_OUT_B 1
`define PFD_OUT_C 2
`define PFD_OUT_D 3
`define PFD_OUT_E 4
`define PFD_OUT_F 5
`endif

// ===== verilog/pfd_pkg.sv
// types shared by the pfd design files
package pfd_pkg;
  // output mode, one-hot field of the control register
  typedef enum logic [2:0] {
    PFD_MODE_FDC = 3'h1,
    PFD_MODE_FDC_COMPL = 3'h2,
    PFD_MODE_3PH = 3'h4
  } pfd_mode_e;
  typedef logic [7:0] pfd_byte_t;
endpackage

// ===== verilog/pfd_top.sv
// fixed-duty and 3-phase pwm output stage with dead band
// What this block does
// - fixed-duty toggles primary per period only
// - period event adds 4-bit adjust to accumulator
// - single drives A; complementary drives A,B
// - turn-on: complement off, step, dead band, on
// - turn-off: primary off, step, dead band, complement
// - turn-on uses rising, turn-off falling counter
// - 3-phase uses six outputs, one pair, no dead band
// - A/B phase1, C/D phase2, E/F phase3
// - steering value picks high/low active pair
// - undefined value uses lowest set bit
// - mod enables let side follow edge events
// - both enables clear: outputs held active
// - rising event activates, falling deactivates
// - separate 8-bit rising and falling counters
// - rising band delays primary after complement off
// - falling band delays complement after primary off
// - new band times load at period after request
// - band enables act immediately
// - band counters advance each clock
// - async events add up to one clock jitter
// - falling during rising count aborts, suppresses primary
// - rising during falling count aborts, suppresses complement
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "pfd_defines.svh"
module pfd_top
  import pfd_pkg::*;
#(
  parameter int PER_W = 16,
  parameter int DB_W = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [`PFD_ADDR_W-1:0] i_addr,
  input wire logic [`PFD_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`PFD_DATA_W-1:0] o_rdata,
  // asynchronous edge event pins
  input wire logic i_rise_evt,
  input wire logic i_fall_evt,
  // switch driver outputs
  output logic o_out_a_phase1_high,
  output logic o_out_b_phase1_low,
  output logic o_out_c_phase2_high,
  output logic o_out_d_phase2_low,
  output logic o_out_e_phase3_high,
  output logic o_out_f_phase3_low
);
  // software registers
  logic [`PFD_DATA_W-1:0] ctrl_q, ctrl_d; // pwm_control
  logic [PER_W-1:0] per_q, per_d; // period length
  logic [`PFD_FFA_W-1:0] ffa_q, ffa_d; // fractional_freq_adjust
  logic [DB_W-1:0] dbr_q, dbr_d; // rise_deadband_time, written
  logic [DB_W-1:0] dbf_q, dbf_d; // fall_deadband_time, written
  logic [DB_W-1:0] dbr_act_q, dbr_act_d; // rising time in use
  logic [DB_W-1:0] dbf_act_q, dbf_act_d; // falling time in use
  logic [`PFD_STR_W-1:0] str_q, str_d; // steering_select
  logic [1:0] str1_q, str1_d; // steering_control_1
  logic [`PFD_DATA_W-1:0] rdata_q, rdata_d;
  // event synchronisers and filtered levels
  logic [2:0] rsync_q, rsync_d;
  logic [2:0] fsync_q, fsync_d;
  logic rlvl_q, rlvl_d;
  logic flvl_q, flvl_d;
  // period engine
  logic [PER_W-1:0] pcnt_q, pcnt_d;
  logic [`PFD_FFA_W-1:0] acc_q, acc_d; // fractional_accumulator
  logic stretch_q, stretch_d;
  logic prim_q, prim_d; // primary level before dead band
  logic hmod_q, hmod_d; // high-side modulation level
  logic lmod_q, lmod_d; // low-side modulation level
  logic [5:0] out_q, out_d; // A..F registered outputs
  // combinational helpers
  logic enable, ld_req, dbre, dbfe, hsmen, lsmen;
  logic per_evt, rise_ev, fall_ev, rb, fb;
  logic db_rise_start, db_fall_start;
  logic [`PFD_FFA_W:0] acc_sum;
  pfd_mode_e mode;

  // lowest set steering bit picks the pair; bit0 high, bit1 low side
  // returns one-hot high-side index over A,C,E and low over B,D,F
  function automatic logic [5:0] steer_decode(
    input logic [`PFD_STR_W-1:0] sel, input logic hi, input logic lo);
    logic [5:0] r;
    r = 6'h00;
    // pairs A+D, A+F, C+F, C+B, E+B, E+D
    if (sel[0]) begin
      r[`PFD_OUT_A] = hi;
      r[`PFD_OUT_D] = lo;
    end else if (sel[1]) begin
      r[`PFD_OUT_A] = hi;
      r[`PFD_OUT_F] = lo;
    end else if (sel[2]) begin
      r[`PFD_OUT_C] = hi;
      r[`PFD_OUT_F] = lo;
    end else if (sel[3]) begin
      r[`PFD_OUT_C] = hi;
      r[`PFD_OUT_B] = lo;
    end else if (sel[4]) begin
      r[`PFD_OUT_E] = hi;
      r[`PFD_OUT_B] = lo;
    end else if (sel[5]) begin
      r[`PFD_OUT_E] = hi;
      r[`PFD_OUT_D] = lo;
    end
    return r;
  endfunction

  // control field decode
  always_comb begin
    enable = ctrl_q[`PFD_CTRL_EN];
    ld_req = ctrl_q[`PFD_CTRL_LD];
    dbre = ctrl_q[`PFD_CTRL_DBRE];
    dbfe = ctrl_q[`PFD_CTRL_DBFE];
    mode = pfd_mode_e'(ctrl_q[`PFD_CTRL_MODE_HI:`PFD_CTRL_MODE_LO]);
    hsmen = str1_q[`PFD_STR1_HSMEN];
    lsmen = str1_q[`PFD_STR1_LSMEN];
  end

  // event pins: three flops, a change counts once stages 2 and 3 agree
  // sampling adds up to one clock of jitter
  always_comb begin
    rsync_d = {rsync_q[1:0], i_rise_evt};
    fsync_d = {fsync_q[1:0], i_fall_evt};
    rlvl_d = (rsync_q[1] == rsync_q[2]) ? rsync_q[2] : rlvl_q;
    flvl_d = (fsync_q[1] == fsync_q[2]) ? fsync_q[2] : flvl_q;
    rise_ev = rlvl_d & ~rlvl_q;
    fall_ev = flvl_d & ~flvl_q;
  end

  // register writes, load handshake and read-back
  always_comb begin
    ctrl_d = ctrl_q;
    per_d = per_q;
    ffa_d = ffa_q;
    dbr_d = dbr_q;
    dbf_d = dbf_q;
    dbr_act_d = dbr_act_q;
    dbf_act_d = dbf_act_q;
    str_d = str_q;
    str1_d = str1_q;
    rdata_d = rdata_q;
    // pending request moves times in at a period event
    if (!enable || (ld_req && per_evt)) begin
      dbr_act_d = dbr_q;
      dbf_act_d = dbf_q;
    end
    // load request clears once served
    if (ld_req && per_evt) begin
      ctrl_d[`PFD_CTRL_LD] = 1'b0;
    end
    // a write in the same cycle wins over the hardware clear
    if (i_wr) begin
      unique case (i_addr)
        `PFD_OFS_CTRL: ctrl_d = i_wdata;
        `PFD_OFS_PER_LO: per_d[7:0] = i_wdata;
        `PFD_OFS_PER_HI: per_d[PER_W-1:8] = i_wdata[PER_W-9:0];
        `PFD_OFS_FFA: ffa_d = i_wdata[`PFD_FFA_W-1:0];
        `PFD_OFS_DBR: dbr_d = i_wdata[DB_W-1:0];
        `PFD_OFS_DBF: dbf_d = i_wdata[DB_W-1:0];
        `PFD_OFS_STR0: str_d = i_wdata[`PFD_STR_W-1:0];
        `PFD_OFS_STR1: str1_d = i_wdata[1:0];
        default: ; // unmapped writes are dropped
      endcase
    end
    // read data valid in the next cycle only
    rdata_d = `PFD_RST_BYTE;
    if (i_rd) begin
      unique case (i_addr)
        `PFD_OFS_CTRL: rdata_d = ctrl_q;
        `PFD_OFS_PER_LO: rdata_d = per_q[7:0];
        `PFD_OFS_PER_HI: rdata_d = per_q[PER_W-1:8];
        `PFD_OFS_FFA: rdata_d = {4'h0, ffa_q};
        `PFD_OFS_DBR: rdata_d = dbr_q;
        `PFD_OFS_DBF: rdata_d = dbf_q;
        `PFD_OFS_STR0: rdata_d = {2'h0, str_q};
        `PFD_OFS_STR1: rdata_d = {6'h00, str1_q};
        `PFD_OFS_STAT: rdata_d = {rb, fb, out_q};
        default: rdata_d = `PFD_RST_BYTE;
      endcase
    end
  end

  // period counter, accumulator and waveform levels
  always_comb begin
    pcnt_d = pcnt_q;
    acc_d = acc_q;
    stretch_d = stretch_q;
    prim_d = prim_q;
    hmod_d = hmod_q;
    lmod_d = lmod_q;
    per_evt = 1'b0;
    db_rise_start = 1'b0;
    db_fall_start = 1'b0;
    acc_sum = {1'b0, acc_q} + {1'b0, ffa_q};
    if (!enable) begin
      pcnt_d = '0;
      stretch_d = 1'b0;
      prim_d = 1'b0;
      hmod_d = 1'b0;
      lmod_d = 1'b0;
    end else if (pcnt_q == per_q) begin
      // overflow holds the count one extra clock
      if (stretch_q) begin
        stretch_d = 1'b0;
      end else begin
        per_evt = 1'b1;
        pcnt_d = '0;
      end
    end else begin
      pcnt_d = pcnt_q + 1'b1;
    end
    unique case (mode)
      PFD_MODE_FDC, PFD_MODE_FDC_COMPL: begin
        // toggle at period, edge events ignored
        if (per_evt) begin
          prim_d = ~prim_q;
          acc_d = acc_sum[`PFD_FFA_W-1:0];
          stretch_d = acc_sum[`PFD_FFA_W];
          if (mode == PFD_MODE_FDC_COMPL) begin
            db_rise_start = ~prim_q & dbre;
            db_fall_start = prim_q & dbfe;
          end
        end
      end
      PFD_MODE_3PH: begin
        // rising sets, falling clears
        // a falling event in the same clock has the last word
        if (rise_ev) begin
          hmod_d = 1'b1;
          lmod_d = 1'b1;
        end
        if (fall_ev) begin
          hmod_d = 1'b0;
          lmod_d = 1'b0;
        end
      end
      default: prim_d = 1'b0; // illegal mode code keeps outputs off
    endcase
  end

  pfd_deadband #(
    .CNT_W(DB_W)
  ) u_deadband (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_rise_start(db_rise_start),
    .i_fall_start(db_fall_start),
    .i_rise_en(dbre),
    .i_fall_en(dbfe),
    .i_rise_time(dbr_act_q),
    .i_fall_time(dbf_act_q),
    .o_rise_busy(rb),
    .o_fall_busy(fb)
  );

  // output steering per mode; every pin is registered below
  always_comb begin
    out_d = 6'h00;
    if (enable) begin
      unique case (mode)
        PFD_MODE_FDC: out_d[`PFD_OUT_A] = prim_q;
        PFD_MODE_FDC_COMPL: begin
          out_d[`PFD_OUT_A] = prim_q & ~rb & ~db_rise_start;
          out_d[`PFD_OUT_B] = ~prim_q & ~fb & ~db_fall_start;
        end
        PFD_MODE_3PH: begin
          // both clear holds the rising state
          out_d = steer_decode(str_q, hsmen ? hmod_q : 1'b1,
                               lsmen ? lmod_q : 1'b1);
        end
        default: out_d = 6'h00;
      endcase
    end
  end

  // all state registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= `PFD_RST_CTRL;
      per_q <= `PFD_RST_PER;
      ffa_q <= `PFD_RST_FFA;
      dbr_q <= `PFD_RST_BYTE;
      dbf_q <= `PFD_RST_BYTE;
      dbr_act_q <= `PFD_RST_BYTE;
      dbf_act_q <= `PFD_RST_BYTE;
      str_q <= `PFD_RST_STR;
      str1_q <= `PFD_RST_STR1;
      rdata_q <= `PFD_RST_BYTE;
      rsync_q <= 3'h0;
      fsync_q <= 3'h0;
      rlvl_q <= 1'b0;
      flvl_q <= 1'b0;
      pcnt_q <= '0;
      acc_q <= `PFD_RST_FFA;
      stretch_q <= 1'b0;
      prim_q <= 1'b0;
      hmod_q <= 1'b0;
      lmod_q <= 1'b0;
      out_q <= 6'h00;
    end else begin
      ctrl_q <= ctrl_d;
      per_q <= per_d;
      ffa_q <= ffa_d;
      dbr_q <= dbr_d;
      dbf_q <= dbf_d;
      dbr_act_q <= dbr_act_d;
      dbf_act_q <= dbf_act_d;
      str_q <= str_d;
      str1_q <= str1_d;
      rdata_q <= rdata_d;
      rsync_q <= rsync_d;
      fsync_q <= fsync_d;
      rlvl_q <= rlvl_d;
      flvl_q <= flvl_d;
      pcnt_q <= pcnt_d;
      acc_q <= acc_d;
      stretch_q <= stretch_d;
      prim_q <= prim_d;
      hmod_q <= hmod_d;
      lmod_q <= lmod_d;
      out_q <= out_d;
    end
  end

  // outputs straight from flops
  assign o_rdata = rdata_q;
  assign o_out_a_phase1_high = out_q[`PFD_OUT_A];
  assign o_out_b_phase1_low = out_q[`PFD_OUT_B];
  assign o_out_c_phase2_high = out_q[`PFD_OUT_C];
  assign o_out_d_phase2_low = out_q[`PFD_OUT_D];
  assign o_out_e_phase3_high = out_q[`PFD_OUT_E];
  assign o_out_f_phase3_low = out_q[`PFD_OUT_F];
endmodule
`default_nettype wire
